// *** design/opc_otp_ctrl.sv ***
// opc_otp_ctrl: programming, security and checksum control of the code memory.
// assumes a combinational-read memory array on mem_addr_o and a wishbone master.
//
// Overview of operation
// - 0x1E00..0x1FFE never hold program bytes
// - byte program keeps busy for 100 us
// - writing 0x04 to device control halts core
// - data write programs byte, address plus one
// - programmer polls busy, fail means write failed
// - 0x02 then 0x00 to device control resets
// - security byte lives at 0x1FFF
// - security byte readable whenever idle, even when read-locked
// - any zero in bits 7..4 blocks writes
// - zero bit 3 blocks code reads
// - locks are permanent, set write lock last
// - checksum works even when fully locked
// - block checksum only on aligned 256 bytes
// - write to checksum byte 1 starts 32-bit
// - busy set during checksum, cleared after
// - 32-bit result spans bytes 3 down to 0
// - 32-bit polynomial 0x04C11DB7
// - write to byte 0 starts block checksum
// - block polynomial 0x1021, result bytes 1:0
`timescale 1ns/1ps
module opc_otp_ctrl
	import opc_pkg::*;
#(
	parameter logic [15:0] USER_LIMIT = opc_pkg::USER_LIMIT_DEF
) (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// programming supply present, asynchronous pin
	input  wire logic        vpp_ok_i,
	// code memory array
	output logic      [15:0] mem_addr_o,
	output logic      [7:0]  mem_wdata_o,
	output logic             mem_wr_o,
	input  wire logic [7:0]  mem_rdata_i,
	// system control
	output logic             core_reset_o,
	output logic             sys_reset_o
);
	import opc_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	opc_regs_s   s_r;
	opc_regs_s   s_nxt;
	logic        vpp_ok;
	logic [31:0] crc32_step;
	logic [15:0] crc16_step;

	// address hits one register offset
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		return adr == off;
	endfunction

	// no program byte may land in the reserved top, the security byte apart, or above user space
	function automatic logic no_store(input logic [15:0] a);
		return (a > USER_LIMIT || a >= RSV_START) && a != SEC_ADDR;
	endfunction

	opc_sync2 u_vpp_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (vpp_ok_i),
		.q_o   (vpp_ok)
	);

	opc_crc_step #(.W(32), .POLY(POLY32)) u_crc32 (
		.crc_i  (s_r.crc),
		.data_i (mem_rdata_i),
		.crc_o  (crc32_step)
	);

	opc_crc_step #(.W(16), .POLY(POLY16)) u_crc16 (
		.crc_i  (s_r.crc[15:0]),
		.data_i (mem_rdata_i),
		.crc_o  (crc16_step)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic req;
		logic wr;
		logic idle;
		logic wlock;
		logic rlock;
		logic [7:0] wb;
		req   = wb_cyc_i && wb_stb_i && !s_r.ack;
		wr    = req && wb_we_i && wb_sel_i[0];
		idle  = s_r.st == ST_IDLE;
		wlock = ~&s_r.sec[WLOCK_HI:WLOCK_LO];
		rlock = ~s_r.sec[RLOCK_BIT];
		wb    = wb_dat_i[7:0];

		s_nxt         = s_r;
		s_nxt.mem_wr  = 1'b0;
		s_nxt.sys_rst = 1'b0;
		s_nxt.ack     = req;
		s_nxt.dat     = '0;

		// register reads, unmapped offsets answer zero
		if (req && !wb_we_i) begin
			if (hit(wb_adr_i, OFF_DEV_CTL))
				s_nxt.dat[7:0] = s_r.dev_ctl;
			if (hit(wb_adr_i, OFF_PROG_CTL))
				s_nxt.dat[7:0] = s_r.prog_ctl;
			if (hit(wb_adr_i, OFF_ADDR_HIGH))
				s_nxt.dat[7:0] = s_r.addr[15:8];
			if (hit(wb_adr_i, OFF_ADDR_LOW))
				s_nxt.dat[7:0] = s_r.addr[7:0];
			// a locked part shows zeros, except the security byte itself
			if (hit(wb_adr_i, OFF_PROG_DATA) && idle &&
			    (!rlock || s_r.addr == SEC_ADDR))
				s_nxt.dat[7:0] = mem_rdata_i;
			if (hit(wb_adr_i, OFF_IF_ADDR)) begin
				s_nxt.dat[BUSY_BIT] = !idle;
				s_nxt.dat[FAIL_BIT] = s_r.fail;
			end
			if (hit(wb_adr_i, OFF_CHK0))
				s_nxt.dat[7:0] = s_r.crc[7:0];
			if (hit(wb_adr_i, OFF_CHK1))
				s_nxt.dat[7:0] = s_r.crc[15:8];
			if (hit(wb_adr_i, OFF_CHK2))
				s_nxt.dat[7:0] = s_r.crc[23:16];
			if (hit(wb_adr_i, OFF_CHK3))
				s_nxt.dat[7:0] = s_r.crc[31:24];
		end

		// background work
		case (s_r.st)
			ST_SEC: begin
				// memory address sits on the security byte out of reset
				s_nxt.sec = mem_rdata_i;
				s_nxt.st  = ST_IDLE;
			end
			ST_IDLE: begin
				// array follows the address register so reads are ready
				s_nxt.mem_addr = s_r.addr;
			end
			ST_PROG: begin
				s_nxt.cnt = s_r.cnt - 1'b1;
				if (s_r.cnt == CNT_W'(1))
					s_nxt.st = ST_IDLE;
			end
			ST_CRC: begin
				// one byte a cycle, locks do not apply here
				if (s_r.mode32)
					s_nxt.crc = crc32_step;
				else
					s_nxt.crc[15:0] = crc16_step;
				if (s_r.mem_addr == s_r.end_addr)
					s_nxt.st = ST_IDLE;
				else
					s_nxt.mem_addr = s_r.mem_addr + 16'h0001;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase

		// register writes
		if (wr) begin
			if (hit(wb_adr_i, OFF_DEV_CTL)) begin
				s_nxt.dev_ctl = wb;
				if (wb == DC_HALT)
					s_nxt.core_rst = 1'b1;
				if (wb == CMD_ZERO && s_r.dev_ctl == DC_RESET_ARM) begin
					s_nxt.sys_rst  = 1'b1;
					s_nxt.core_rst = 1'b0;
				end
			end
			if (hit(wb_adr_i, OFF_PROG_CTL)) begin
				s_nxt.prog_ctl = wb;
				// entry needs the two steps back to back
				if (wb == PC_STEP2 && s_r.prog_ctl == PC_STEP1)
					s_nxt.prog_mode = 1'b1;
				if (wb == CMD_ZERO)
					s_nxt.prog_mode = 1'b0;
			end
			if (hit(wb_adr_i, OFF_ADDR_HIGH))
				s_nxt.addr[15:8] = wb;
			if (hit(wb_adr_i, OFF_ADDR_LOW))
				s_nxt.addr[7:0] = wb;
			// new work only when idle, else silently dropped
			if (hit(wb_adr_i, OFF_PROG_DATA) && idle) begin
				if (!s_r.prog_mode || !s_r.core_rst || !vpp_ok || wlock ||
				    no_store(s_r.addr)) begin
					s_nxt.fail = 1'b1;
				end else begin
					s_nxt.fail      = 1'b0;
					s_nxt.mem_addr  = s_r.addr;
					s_nxt.mem_wdata = wb;
					s_nxt.mem_wr    = 1'b1;
					s_nxt.cnt       = PROG_CNT;
					s_nxt.st        = ST_PROG;
					s_nxt.addr      = s_r.addr + 16'h0001;
					// cells only clear, so locks never come back off
					if (s_r.addr == SEC_ADDR)
						s_nxt.sec = s_r.sec & wb;
				end
			end
			if (hit(wb_adr_i, OFF_CHK1) && idle) begin
				s_nxt.mode32   = 1'b1;
				s_nxt.crc      = CRC32_INIT;
				s_nxt.mem_addr = 16'h0000;
				s_nxt.end_addr = USER_LIMIT;
				s_nxt.st       = ST_CRC;
			end
			// only the high byte is taken, so blocks are always aligned
			if (hit(wb_adr_i, OFF_CHK0) && idle) begin
				s_nxt.mode32    = 1'b0;
				s_nxt.crc[15:0] = CRC16_INIT;
				s_nxt.mem_addr  = {wb, 8'h00};
				s_nxt.end_addr  = {wb, BLOCK_LAST};
				s_nxt.st        = ST_CRC;
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	// single register for the whole state, frozen while ce_i is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r           <= '0;
			s_r.st        <= ST_SEC;
			s_r.sec       <= SEC_RESET;
			s_r.mem_addr  <= SEC_ADDR;
			s_r.crc       <= CRC32_INIT;
			s_r.end_addr  <= USER_LIMIT_DEF;
		end else if (ce_i) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o     = s_r.dat;
	assign wb_ack_o     = s_r.ack;
	assign mem_addr_o   = s_r.mem_addr;
	assign mem_wdata_o  = s_r.mem_wdata;
	assign mem_wr_o     = s_r.mem_wr;
	assign core_reset_o = s_r.core_rst;
	assign sys_reset_o  = s_r.sys_rst;

endmodule // opc_otp_ctrl

// *** design/opc_pkg.sv ***
// opc_pkg: constants, register map and state types of the one-time-programmable
// code memory controller (programming, security byte, checksum engine).
// assumes a 10 MHz system clock and a 32-bit classic wishbone register bus.
package opc_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int CLK_MHZ      = 10;          // system clock rate in MHz
	localparam int PROG_TIME_US = 100;         // one byte program, microseconds
	localparam int PROG_CYC     = PROG_TIME_US * CLK_MHZ;
	localparam int CNT_W        = 11;
	localparam logic [CNT_W-1:0] PROG_CNT = CNT_W'(PROG_CYC);

	// ****************************************************************
	// register byte offsets on the bus
	// ****************************************************************
	localparam logic [7:0] OFF_DEV_CTL   = 8'h00;  // device_control_reg
	localparam logic [7:0] OFF_PROG_CTL  = 8'h04;  // program_control_reg
	localparam logic [7:0] OFF_ADDR_HIGH = 8'h08;  // prog_address_high
	localparam logic [7:0] OFF_ADDR_LOW  = 8'h0c;  // prog_address_low
	localparam logic [7:0] OFF_PROG_DATA = 8'h10;  // prog_data_reg
	localparam logic [7:0] OFF_IF_ADDR   = 8'h14;  // interface_address_reg (status)
	localparam logic [7:0] OFF_CHK0      = 8'h18;  // checksum_byte_0
	localparam logic [7:0] OFF_CHK1      = 8'h1c;  // checksum_byte_1
	localparam logic [7:0] OFF_CHK2      = 8'h20;  // checksum_byte_2
	localparam logic [7:0] OFF_CHK3      = 8'h24;  // checksum_byte_3

	// ****************************************************************
	// fields, command values and reset values
	// ****************************************************************
	localparam int BUSY_BIT = 7;               // memory_busy_flag position
	localparam int FAIL_BIT = 6;               // memory_fail_flag position
	localparam int WLOCK_HI = 7;               // write lock field, bits 7..4
	localparam int WLOCK_LO = 4;
	localparam int RLOCK_BIT = 3;              // read lock bit
	localparam logic [7:0] DC_HALT      = 8'h04;
	localparam logic [7:0] DC_RESET_ARM = 8'h02;
	localparam logic [7:0] CMD_ZERO     = 8'h00;
	localparam logic [7:0] PC_STEP1     = 8'h40;
	localparam logic [7:0] PC_STEP2     = 8'h58;
	localparam logic [15:0] RSV_START   = 16'h1e00;
	localparam logic [15:0] SEC_ADDR    = 16'h1fff;
	localparam logic [15:0] USER_LIMIT_DEF = 16'h1dff;
	localparam logic [7:0] SEC_RESET    = 8'h00;   // locked until the byte is loaded
	localparam logic [7:0] BLOCK_LAST   = 8'hff;
	localparam logic [31:0] POLY32      = 32'h04c11db7;
	localparam logic [15:0] POLY16      = 16'h1021;
	localparam logic [31:0] CRC32_INIT  = 32'hffffffff;
	localparam logic [15:0] CRC16_INIT  = 16'hffff;

	// ****************************************************************
	// controller state
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_SEC  = 2'b00,
		ST_IDLE = 2'b01,
		ST_PROG = 2'b10,
		ST_CRC  = 2'b11
	} opc_state_e;

	typedef struct packed {
		opc_state_e       st;
		logic [7:0]       dev_ctl;
		logic [7:0]       prog_ctl;
		logic             prog_mode;
		logic [15:0]      addr;
		logic [7:0]       sec;
		logic             fail;
		logic [CNT_W-1:0] cnt;
		logic             mode32;
		logic [15:0]      end_addr;
		logic [31:0]      crc;
		logic [15:0]      mem_addr;
		logic [7:0]       mem_wdata;
		logic             mem_wr;
		logic             core_rst;
		logic             sys_rst;
		logic             ack;
		logic [31:0]      dat;
	} opc_regs_s;

endpackage

// *** design/opc_sync2.sv ***
// opc_sync2: two flip-flop synchroniser for a level from outside the clock domain.
// assumes the level is slow compared with the clock; only stage two is read.
`timescale 1ns/1ps
module opc_sync2 (
	// clock, reset, enable
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// level in and out
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			q_o    <= 1'b0;
		end else if (ce_i) begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule // opc_sync2

// *** design/opc_crc_step.sv ***
// opc_crc_step: one byte of a most-significant-bit-first crc update, no reflection.
// assumes the caller holds the running value; purely combinational.
`timescale 1ns/1ps
module opc_crc_step #(
	parameter int           W    = 16,
	parameter logic [W-1:0] POLY = '0
) (
	// running value and byte in
	input  wire logic [W-1:0] crc_i,
	input  wire logic [7:0]   data_i,
	// updated value
	output logic [W-1:0]      crc_o
);
	// eight shifts, byte enters at the top
	always_comb begin
		logic [W-1:0] c;
		c = crc_i ^ {data_i, {(W-8){1'b0}}};
		for (int i = 0; i < 8; i++) begin
			c = c[W-1] ? ((c << 1) ^ POLY) : (c << 1);
		end
		crc_o = c;
	end
endmodule // opc_crc_step

// *** testbench/opc_otp_ctrl_sva.sv ***
// opc_otp_ctrl_sva: port checks of the code memory controller.
// assumes ce_i is high whenever the bus is used.
`timescale 1ns/1ps
module opc_otp_ctrl_sva #(
	parameter logic [15:0] USER_LIMIT = 16'h1dff
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic [7:0]  mem_wdata_o,
	input wire logic        mem_wr_o,
	input wire logic        core_reset_o,
	input wire logic        sys_reset_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a request the slave takes on this edge
	wire take = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	ack_next_a: assert property (take |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	rd_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	prog_range_a: assert property (mem_wr_o |->
		(mem_addr_o <= USER_LIMIT && mem_addr_o < 16'h1e00) || mem_addr_o == 16'h1fff)
		else $error("program pulse outside user space");
	prog_gap_a: assert property (mem_wr_o |=> (!mem_wr_o)[*8])
		else $error("second program pulse while busy");
	data_hold_a: assert property (mem_wr_o |=> $stable(mem_wdata_o))
		else $error("program data not held");
	halt_core_a: assert property (take && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == 8'h00 && wb_dat_i[7:0] == 8'h04 |=> ##[0:1] core_reset_o)
		else $error("halt did not hold core");
	sys_pulse_a: assert property (sys_reset_o |=> !sys_reset_o && !core_reset_o)
		else $error("device reset not a single pulse");
	cover property (mem_wr_o);
	cover property (sys_reset_o);
	cover property (take && wb_we_i && wb_adr_i == 8'h1c);
endmodule // opc_otp_ctrl_sva

bind opc_otp_ctrl opc_otp_ctrl_sva #(.USER_LIMIT(USER_LIMIT)) i_sva (.clk_i(clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
	.mem_wr_o(mem_wr_o), .core_reset_o(core_reset_o), .sys_reset_o(sys_reset_o));

// *** testbench/opc_mem_model.sv ***
// opc_mem_model: behavioural one-time-programmable array.
// assumes program pulses come from the controller; reads are combinational.
`timescale 1ns/1ps
module opc_mem_model (
	// programming port
	input  wire logic        clk_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	// read port
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [0:8191];
	// blank cells read ff, block zero holds a pattern for the checksums
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = (i < 256) ? 8'(i) ^ 8'h3c : 8'hff;
		end
	end
	// cells only lose ones, so no lock can be undone
	always @(posedge clk_i) begin
		if (wr_i) begin
			mem[addr_i[12:0]] <= mem[addr_i[12:0]] & wdata_i;
		end
	end
	assign rdata_o = mem[addr_i[12:0]];
endmodule // opc_mem_model

// *** testbench/opc_otp_ctrl_tb.sv ***
// opc_otp_ctrl_tb: self-checking bench of the code memory controller.
// assumes the array model beside it; ce_i high, byte lane 0 only.
`timescale 1ns/1ps
module opc_otp_ctrl_tb;
	import opc_pkg::*;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, vpp = 0;
	logic [7:0]  adr = 8'h00, rdata, mem_wdata_o, mem_rdata;
	logic [31:0] dat = 32'h0, wb_dat_o, q;
	logic        wb_ack_o, mem_wr_o, core_reset_o, sys_reset_o;
	logic [15:0] mem_addr_o;
	int          err_total = 0, comparisons = 0, pulses = 0;
	always #50 clk_i = ~clk_i;
	opc_otp_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vpp_ok_i(vpp), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o), .mem_rdata_i(mem_rdata),
		.core_reset_o(core_reset_o), .sys_reset_o(sys_reset_o));
	opc_mem_model i_mem (.clk_i(clk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
		.wr_i(mem_wr_o), .rdata_o(mem_rdata));
	// ****************************************************************
	// helpers
	// ****************************************************************
	always @(posedge clk_i) begin
		if (sys_reset_o === 1'b1) pulses++;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic idle();
		do wb(0, OFF_IF_ADDR, 8'h00); while (q[BUSY_BIT] !== 1'b0);
	endtask
	task automatic at(input logic [15:0] a);
		wb(1, OFF_ADDR_HIGH, a[15:8]);
		wb(1, OFF_ADDR_LOW, a[7:0]);
	endtask
	// reference checksum, most significant bit first
	function automatic logic [31:0] crc(input int w, input int lo, input int hi);
		logic [31:0] c;
		c = (w == 32) ? 32'hffffffff : 32'h0000ffff;
		for (int a = lo; a <= hi; a++) begin
			c ^= {24'h0, i_mem.mem[a]} << (w - 8);
			for (int k = 0; k < 8; k++) c = c[w-1] ? (c << 1) ^ ((w == 32) ? 32'h04c11db7
				: 32'h00001021) : c << 1;
		end
		return (w == 32) ? c : c & 32'h0000ffff;
	endfunction
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_prog();
		wb(1, OFF_DEV_CTL, DC_HALT);
		repeat (2) @(posedge clk_i);
		chk(core_reset_o, 32'h1);
		wb(1, OFF_PROG_CTL, PC_STEP1);
		wb(1, OFF_PROG_CTL, PC_STEP2);
		vpp <= 1;
		repeat (4) @(posedge clk_i);
		at(16'h0100);
		wb(1, OFF_PROG_DATA, 8'ha5);
		wb(1, OFF_PROG_DATA, 8'h5a);
		repeat (986) @(posedge clk_i);
		wb(0, OFF_IF_ADDR, 8'h00);
		chk(q[BUSY_BIT], 32'h1);
		repeat (8) @(posedge clk_i);
		wb(0, OFF_IF_ADDR, 8'h00);
		chk(q[BUSY_BIT], 32'h0);
		chk(i_mem.mem[16'h0100], 32'ha5);
		wb(0, OFF_PROG_DATA, 8'h00);
		chk(q, 32'hff);
		wb(1, OFF_PROG_DATA, 8'h5a);
		idle();
		chk(i_mem.mem[16'h0101], 32'h5a);
		at(RSV_START);
		wb(1, OFF_PROG_DATA, 8'h00);
		idle();
		chk(q[FAIL_BIT], 32'h1);
		chk(i_mem.mem[16'h1e00], 32'hff);
	endtask
	task automatic t_blk(input logic [7:0] h);
		wb(1, OFF_CHK0, h);
		wb(0, OFF_IF_ADDR, 8'h00);
		chk(q[BUSY_BIT], 32'h1);
		idle();
		wb(0, OFF_CHK1, 8'h00);
		rdata = q[7:0];
		wb(0, OFF_CHK0, 8'h00);
		chk({rdata, q[7:0]}, crc(16, {h, 8'h00}, {h, 8'hff}));
	endtask
	task automatic t_lock();
		at(SEC_ADDR);
		wb(1, OFF_PROG_DATA, 8'h07);
		idle();
		at(16'h0000);
		wb(0, OFF_PROG_DATA, 8'h00);
		chk(q, 32'h0);
		wb(1, OFF_PROG_DATA, 8'h00);
		idle();
		chk(q[FAIL_BIT], 32'h1);
		chk(i_mem.mem[0], 32'h3c);
		at(SEC_ADDR);
		wb(0, OFF_PROG_DATA, 8'h00);
		chk(q, 32'h07);
		t_blk(8'h00);
	endtask
	task automatic t_full();
		logic [31:0] r;
		wb(1, OFF_PROG_CTL, PC_STEP1);
		vpp <= 0;
		wb(1, OFF_PROG_CTL, CMD_ZERO);
		wb(1, OFF_DEV_CTL, DC_RESET_ARM);
		wb(1, OFF_DEV_CTL, CMD_ZERO);
		repeat (2) @(posedge clk_i);
		chk(pulses, 32'h1);
		chk(core_reset_o, 32'h0);
		rst_i <= 1;
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		repeat (3) @(posedge clk_i);
		wb(1, OFF_CHK1, 8'h00);
		wb(0, OFF_IF_ADDR, 8'h00);
		chk(q[BUSY_BIT], 32'h1);
		idle();
		for (int i = 0; i < 4; i++) begin
			wb(0, OFF_CHK3 - 8'(4 * i), 8'h00);
			r = {r[23:0], q[7:0]};
		end
		chk(r, crc(32, 0, USER_LIMIT_DEF));
	endtask
	task automatic end_sim();
		$display("mismatches %0d of %0d comparisons", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		repeat (200) @(posedge clk_i);
		t_prog();
		t_blk(8'h00);
		t_blk(8'h01);
		t_lock();
		t_full();
		end_sim();
	end
	initial begin
		#3000000;
		err_total++;
		end_sim();
	end
endmodule // opc_otp_ctrl_tb
